// ===== src/tsr_top.v
// What this block does
// - status bits 0,1 flag coarse range under/over
// - status bits 2,3 flag fine range under/over
// - status bit 4 flags successful conversion
// - setup bit 0 picks raw or calibrated
// - setup bits 3:1 select 7..12 bit resolution
// - setup bit 6 enables voltage calibration
// - factor A unsigned 10.6, reset zero
// - factor B signed 10.6, read/write
// - factor alpha unsigned 6.10, reset zero
// - thresholds compare calibrated temperature only
// - below low threshold raises low event
// - above high threshold raises high event
// - enable bit 0 gates ready interrupt
// - enable bit 1 gates low interrupt
// - enable bit 2 gates high interrupt
// - start bit self clears at conversion end
// - reading result clears all pending events
// - raw status shows events regardless of enable
// - clear register ones clear matching events
//
// Purpose: register side of an on-die temperature sensor
// Assumes: converter reports results on conv_* inputs from the same clock
// Notes:   register reads return data one cycle after the read strobe
//          events are sticky; a new event beats a same-cycle clear
//          conv_done wins over a start write in the same cycle
`timescale 1ns/100ps
`include "tsr_regs.vh"
module tsr_top
(
   // clock and reset
   input  wire        ref_clk,
   input  wire        rstn,
   // register port
   input  wire [5:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   // converter side
   output wire        conv_start,
   output wire [2:0]  conv_resolution,
   output wire        conv_format,
   output wire        conv_vcal_enable,
   output wire [15:0] conv_cal_a,
   output wire [15:0] conv_cal_b,
   output wire [15:0] conv_cal_alpha,
   input  wire        conv_done,
   input  wire [15:0] conv_raw,
   input  wire [15:0] conv_calibrated,
   input  wire        conv_coarse_under,
   input  wire        conv_coarse_over,
   input  wire        conv_fine_under,
   input  wire        conv_fine_over,
   input  wire        conv_success,
   // interrupt to processor
   output wire        sensor_irq
);
   // control and setup state
   reg        start_bit;
   reg        result_format_select;
   reg [2:0]  resolution_select;
   reg        voltage_calib_enable;
   reg [15:0] calib_factor_a;
   reg [15:0] calib_factor_b;
   reg [15:0] calib_factor_alpha;
   reg [15:0] low_temp_threshold;
   reg [15:0] high_temp_threshold;
   reg [2:0]  irq_enable_mask;
   // conversion results and status
   reg [15:0] result_register;
   reg        coarse_under_range;
   reg        coarse_over_range;
   reg        fine_under_range;
   reg        fine_over_range;
   reg        conversion_ok;
   reg [2:0]  used_resolution;
   reg        used_format;
   reg [2:0]  raw_irq_status;
   // settings latched at start for the conversion in flight
   reg [2:0]  run_resolution;
   reg        run_format;

   // comparator, event and decode terms
   wire        below_low;
   wire        above_high;
   wire [2:0]  masked_irq_status;
   wire [2:0]  irq_set;
   wire [2:0]  irq_clr;
   wire [15:0] new_result;
   wire        wr_ctrl;
   wire        rd_result;
   wire        start_req;

   // per-register write strobes and packed read words
   wire        wr_setup;
   wire        wr_cal_a;
   wire        wr_cal_b;
   wire        wr_cal_alpha;
   wire        wr_tlow;
   wire        wr_thigh;
   wire        wr_irq_en;
   wire        wr_irq_clr;
   wire [2:0]  setup_res;
   wire [31:0] status_word;
   wire [31:0] setup_word;

   // next values of the event bits and the read data
   reg  [2:0]  next_raw_irq;
   reg  [31:0] next_rdata;

   // decode helper used by every register write
   function wr_hit;
      input [5:0] a;
      input [5:0] off;
      begin
         wr_hit = (a == off);
      end
   endfunction

   // codes under the 7-bit setting have no meaning; hold them at the floor
   function [2:0] clamp_res;
      input [2:0] code;
      begin
         if (code < `TSR_RES_MIN_CODE)
            clamp_res = `TSR_RES_MIN_CODE;
         else
            clamp_res = code;
      end
   endfunction

   assign wr_ctrl   = reg_write && wr_hit(reg_addr, `TSR_OFF_CTRL);
   assign rd_result = reg_read && wr_hit(reg_addr, `TSR_OFF_RESULT);

   // one strobe per writable register keeps the update chain short
   assign wr_setup     = reg_write && wr_hit(reg_addr, `TSR_OFF_SETUP);
   assign wr_cal_a     = reg_write && wr_hit(reg_addr, `TSR_OFF_CAL_A);
   assign wr_cal_b     = reg_write && wr_hit(reg_addr, `TSR_OFF_CAL_B);
   assign wr_cal_alpha = reg_write && wr_hit(reg_addr, `TSR_OFF_CAL_ALPHA);
   assign wr_tlow      = reg_write && wr_hit(reg_addr, `TSR_OFF_TLOW);
   assign wr_thigh     = reg_write && wr_hit(reg_addr, `TSR_OFF_THIGH);
   assign wr_irq_en    = reg_write && wr_hit(reg_addr, `TSR_OFF_IRQ_EN);
   assign wr_irq_clr   = reg_write && wr_hit(reg_addr, `TSR_OFF_IRQ_CLEAR);

   // a start write only counts while idle; a second one has no effect
   assign start_req    = wr_ctrl && reg_wdata[0] && !start_bit;

   // written resolution code after the floor is applied
   assign setup_res    = clamp_res(reg_wdata[3:1]);

   // result follows the format latched when the conversion started
   assign new_result = run_format ? conv_calibrated : conv_raw;

   // compare only the calibrated value, even in raw output mode
   tsr_threshold_cmp u_cmp
   (
      .temp_value (conv_calibrated),
      .low_limit  (low_temp_threshold),
      .high_limit (high_temp_threshold),
      .below_low  (below_low),
      .above_high (above_high)
   );

   // events raised at the end of each conversion
   assign irq_set[`TSR_IRQ_RDY_BIT]  = conv_done;
   assign irq_set[`TSR_IRQ_LOW_BIT]  = conv_done & below_low;
   assign irq_set[`TSR_IRQ_HIGH_BIT] = conv_done & above_high;

   // software clears: clear register ones, or a read of the result
   assign irq_clr = wr_irq_clr ? reg_wdata[2:0] : 3'h0;

   assign masked_irq_status = raw_irq_status & irq_enable_mask;
   assign sensor_irq        = |masked_irq_status;

   // converter sees the live setup; the status keeps the launch copy
   assign conv_start       = start_bit;
   assign conv_resolution  = resolution_select;
   assign conv_format      = result_format_select;
   assign conv_vcal_enable = voltage_calib_enable;
   assign conv_cal_a       = calib_factor_a;
   assign conv_cal_b       = calib_factor_b;
   assign conv_cal_alpha   = calib_factor_alpha;

   // start bit: set by software, cleared by the converter finishing
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         start_bit      <= 1'b0;
         run_resolution <= `TSR_RES_RESET;
         run_format     <= `TSR_FMT_RESET;
      end
      else
      begin
         if (conv_done)
            start_bit <= 1'b0;
         else if (wr_ctrl)
            start_bit <= reg_wdata[0] | start_bit;
         // capture settings only when a new conversion is launched
         if (start_req)
         begin
            run_resolution <= resolution_select;
            run_format     <= result_format_select;
         end
      end
   end

   // software-written setup, calibration, threshold and enable registers
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         result_format_select <= `TSR_FMT_RESET;
         resolution_select    <= `TSR_RES_RESET;
         voltage_calib_enable <= 1'b0;
         calib_factor_a       <= 16'h0000;
         calib_factor_b       <= 16'h0000;
         calib_factor_alpha   <= 16'h0000;
         low_temp_threshold   <= `TSR_TLOW_RESET;
         high_temp_threshold  <= `TSR_THIGH_RESET;
         irq_enable_mask      <= 3'h0;
      end
      else
      begin
         if (wr_setup)
         begin
            result_format_select <= reg_wdata[`TSR_SETUP_FMT_BIT];
            resolution_select    <= setup_res;
            voltage_calib_enable <= reg_wdata[`TSR_SETUP_VCAL_BIT];
         end
         // factors and thresholds keep only their 16 used bits
         else if (wr_cal_a)
            calib_factor_a <= reg_wdata[15:0];
         else if (wr_cal_b)
            calib_factor_b <= reg_wdata[15:0];
         else if (wr_cal_alpha)
            calib_factor_alpha <= reg_wdata[15:0];
         else if (wr_tlow)
            low_temp_threshold <= reg_wdata[15:0];
         else if (wr_thigh)
            high_temp_threshold <= reg_wdata[15:0];
         else if (wr_irq_en)
            irq_enable_mask <= reg_wdata[2:0];
      end
   end

   // result and status captured when the converter reports completion
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         result_register    <= 16'h0000;
         coarse_under_range <= 1'b0;
         coarse_over_range  <= 1'b0;
         fine_under_range   <= 1'b0;
         fine_over_range    <= 1'b0;
         conversion_ok      <= 1'b0;
         used_resolution    <= 3'h0;
         used_format        <= 1'b0;
      end
      else if (conv_done)
      begin
         result_register    <= new_result;
         coarse_under_range <= conv_coarse_under;
         coarse_over_range  <= conv_coarse_over;
         fine_under_range   <= conv_fine_under;
         fine_over_range    <= conv_fine_over;
         conversion_ok      <= conv_success;
         used_resolution    <= run_resolution;
         used_format        <= run_format;
      end
   end

   // next events: a result read drops all, a clear drops its ones, a set wins
   always @*
   begin
      next_raw_irq = raw_irq_status;
      if (rd_result)
         next_raw_irq = 3'h0;
      else
         next_raw_irq = raw_irq_status & ~irq_clr;
      next_raw_irq = next_raw_irq | irq_set;
   end

   // sticky events, shown raw whatever the enables say
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         raw_irq_status <= 3'h0;
      else
         raw_irq_status <= next_raw_irq;
   end

   // packed views of the registers with loose fields; reserved bits read zero
   assign status_word = {23'h0, used_format, used_resolution, conversion_ok,
                         fine_over_range, fine_under_range,
                         coarse_over_range, coarse_under_range};
   assign setup_word  = {25'h0, voltage_calib_enable, 2'h0,
                         resolution_select, result_format_select};

   // read mux; unmapped and write-only offsets return zero
   always @*
   begin
      next_rdata = 32'h00000000;
      if (!reg_read)
         next_rdata = 32'h00000000;
      else if (wr_hit(reg_addr, `TSR_OFF_CTRL))
         next_rdata = {31'h0, start_bit};
      else if (wr_hit(reg_addr, `TSR_OFF_RESULT))
         next_rdata = {16'h0, result_register};
      else if (wr_hit(reg_addr, `TSR_OFF_STATUS))
         next_rdata = status_word;
      else if (wr_hit(reg_addr, `TSR_OFF_SETUP))
         next_rdata = setup_word;
      else if (wr_hit(reg_addr, `TSR_OFF_CAL_A))
         next_rdata = {16'h0, calib_factor_a};
      else if (wr_hit(reg_addr, `TSR_OFF_CAL_B))
         next_rdata = {16'h0, calib_factor_b};
      else if (wr_hit(reg_addr, `TSR_OFF_CAL_ALPHA))
         next_rdata = {16'h0, calib_factor_alpha};
      else if (wr_hit(reg_addr, `TSR_OFF_TLOW))
         next_rdata = {16'h0, low_temp_threshold};
      else if (wr_hit(reg_addr, `TSR_OFF_THIGH))
         next_rdata = {16'h0, high_temp_threshold};
      else if (wr_hit(reg_addr, `TSR_OFF_IRQ_EN))
         next_rdata = {29'h0, irq_enable_mask};
      else if (wr_hit(reg_addr, `TSR_OFF_IRQ_RAW))
         next_rdata = {29'h0, raw_irq_status};
      else if (wr_hit(reg_addr, `TSR_OFF_IRQ_MASKED))
         next_rdata = {29'h0, masked_irq_status};
      else
         next_rdata = 32'h00000000;
   end

   // registered so the data stand for exactly the cycle after the strobe
   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 32'h00000000;
      else
         reg_rdata <= next_rdata;
   end
endmodule

// ===== src/tsr_regs.vh
// Purpose: offsets, field positions and reset values of the temperature sensor register block
// Assumes: word-aligned byte offsets on the register port
// Notes:   definitions only
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
`define TSR_ADDR_W          6
`define TSR_OFF_CTRL        6'h00
`define TSR_OFF_RESULT      6'h04
`define TSR_OFF_STATUS      6'h08
`define TSR_OFF_SETUP       6'h0c
`define TSR_OFF_CAL_A       6'h10
`define TSR_OFF_CAL_B       6'h14
`define TSR_OFF_CAL_ALPHA   6'h18
`define TSR_OFF_TLOW        6'h1c
`define TSR_OFF_THIGH       6'h20
`define TSR_OFF_IRQ_EN      6'h24
`define TSR_OFF_IRQ_RAW     6'h28
`define TSR_OFF_IRQ_MASKED  6'h2c
`define TSR_OFF_IRQ_CLEAR   6'h30
`define TSR_SETUP_FMT_BIT   0
`define TSR_SETUP_RES_LSB   1
`define TSR_SETUP_VCAL_BIT  6
`define TSR_SETUP_RESET     7'h0f
`define TSR_TLOW_RESET      16'h8000
`define TSR_THIGH_RESET     16'h7fff
`define TSR_IRQ_RDY_BIT     0
`define TSR_IRQ_LOW_BIT     1
`define TSR_IRQ_HIGH_BIT    2
`define TSR_RES_MIN_CODE    3'h2
`define TSR_RES_RESET       3'h7
`define TSR_FMT_RESET       1'b1
`define TSR_CONV_BASE_CYC   16'h0010
`endif

// ===== src/tsr_threshold_cmp.v
// Purpose: compare a calibrated result against low and high thresholds
// Assumes: all values signed 10.6 two's complement
// Notes:   pure combinational, no state
`timescale 1ns/100ps
module tsr_threshold_cmp
(
   // values
   input  wire [15:0] temp_value,
   input  wire [15:0] low_limit,
   input  wire [15:0] high_limit,
   // results
   output wire        below_low,
   output wire        above_high
);
   // signed compare so negative temperatures order correctly
   assign below_low  = $signed(temp_value) < $signed(low_limit);
   assign above_high = $signed(temp_value) > $signed(high_limit);
endmodule

// ===== verification/tsr_chk_sva.sv
// Purpose: port checker for the temperature sensor register block
// Assumes: offsets of tsr_regs.vh, one clock
// Notes:   shadows enable and thresholds to predict the irq
`timescale 1ns/100ps
`include "tsr_regs.vh"
module tsr_chk
(
   // clock, reset and bus
   input wire        ref_clk,
   input wire        rstn,
   input wire [5:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_write,
   input wire        reg_read,
   input wire [31:0] reg_rdata,
   // converter and irq
   input wire        conv_start,
   input wire [2:0]  conv_resolution,
   input wire        conv_format,
   input wire        conv_done,
   input wire [15:0] conv_calibrated,
   input wire        sensor_irq
);
   logic [2:0]  en;
   logic [15:0] lo;
   logic [15:0] hi;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // shadows, so the irq can be predicted without the bodies
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         en <= 3'h0;
         lo <= 16'h8000;
         hi <= 16'h7fff;
      end
      else if (reg_write)
      begin
         if (reg_addr == `TSR_OFF_IRQ_EN) en <= reg_wdata[2:0];
         if (reg_addr == `TSR_OFF_TLOW) lo <= reg_wdata[15:0];
         if (reg_addr == `TSR_OFF_THIGH) hi <= reg_wdata[15:0];
      end
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not zero while idle");
   a_start_set: assert property (reg_write && reg_addr == `TSR_OFF_CTRL && reg_wdata[0] && !conv_done
      |=> conv_start) else $error("start bit not set");
   a_start_drop: assert property (conv_done |=> !conv_start)
      else $error("start bit not cleared at end");
   a_setup_load: assert property (reg_write && reg_addr == `TSR_OFF_SETUP && reg_wdata[3:1] > 3'h1
      |=> conv_resolution == $past(reg_wdata[3:1]) && conv_format == $past(reg_wdata[0]))
      else $error("setup not loaded");
   a_res_floor: assert property (conv_resolution >= 3'h2) else $error("resolution code below 2");
   a_irq_mask: assert property (en == 3'h0 |-> !sensor_irq) else $error("irq with all disabled");
   a_rdy_irq: assert property (conv_done ##1 en[0] |-> sensor_irq)
      else $error("ready irq missing");
   a_low_irq: assert property (conv_done && $signed(conv_calibrated) < $signed(lo) ##1 en[1]
      |-> sensor_irq) else $error("low irq missing");
   a_high_irq: assert property (conv_done && $signed(conv_calibrated) > $signed(hi) ##1 en[2]
      |-> sensor_irq) else $error("high irq missing");
   a_read_clear: assert property (reg_read && reg_addr == `TSR_OFF_RESULT && !conv_done
      |=> !sensor_irq) else $error("result read left irq");
   c_conv: cover property (conv_start ##[1:20] conv_done);
   c_irq: cover property (conv_done ##1 sensor_irq);
   c_clr: cover property (sensor_irq ##1 !sensor_irq);
endmodule
bind tsr_top tsr_chk u_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .conv_start, .conv_resolution, .conv_format, .conv_done, .conv_calibrated, .sensor_irq);

// ===== verification/tsr_top_tb.sv
// Purpose: self-checking bench for tsr_top
// Assumes: one-cycle register port, converter driven by the bench
// Notes:   random values from a fixed seed
`timescale 1ns/100ps
module tsr_top_tb;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [5:0]  reg_addr = 6'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic        conv_done = 1'b0;
   logic [15:0] conv_raw = 16'h0;
   logic [15:0] conv_cal = 16'h0;
   logic [4:0]  fl = 5'h0;
   wire  [31:0] reg_rdata;
   wire         conv_start;
   wire         sensor_irq;
   wire  [2:0]  conv_res;
   wire         conv_fmt;
   wire         conv_vcal;
   wire  [15:0] cal_a;
   wire  [15:0] cal_b;
   wire  [15:0] cal_alpha;
   int          mismatches = 0;
   int          comparisons = 0;
   tsr_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_resolution(conv_res), .conv_format(conv_fmt), .conv_vcal_enable(conv_vcal), .conv_cal_a(cal_a),
      .conv_cal_b(cal_b), .conv_cal_alpha(cal_alpha), .conv_done(conv_done), .conv_raw(conv_raw),
      .conv_calibrated(conv_cal),
      .conv_coarse_under(fl[0]), .conv_coarse_over(fl[1]), .conv_fine_under(fl[2]),
      .conv_fine_over(fl[3]), .conv_success(fl[4]), .sensor_irq(sensor_irq));
   // clock
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // bus cycles hold everything until the sampling edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk(nm, reg_rdata, e);
   endtask
   // released inputs show the inverse, never a stale copy
   task automatic conv(input logic [15:0] r, input logic [15:0] c, input logic [4:0] f);
      @(posedge ref_clk);
      conv_done <= 1'b1;
      conv_raw <= r;
      conv_cal <= c;
      fl <= f;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      conv_raw <= ~r;
      conv_cal <= ~c;
      fl <= ~f;
   endtask
   function automatic logic [31:0] exp_setup(input logic [31:0] w);
      return {25'h0, w[6], 2'b00, (w[3:1] < 3'h2) ? 3'h2 : w[3:1], w[0]};
   endfunction
   function automatic logic [31:0] exp_evt(input logic [15:0] c, input logic [15:0] l, input logic [15:0] h);
      return {29'h0, $signed(c) > $signed(h), $signed(c) < $signed(l), 1'b1};
   endfunction
   // hang guard, far above the expected run
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      give_verdict();
   end
   initial
   begin
      logic [31:0] w, s, lo, hi, en, c, r, ev;
      logic [4:0]  f;
      void'($urandom(25019));
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 14; i++)
         rchk("reset", (i < 13) ? 6'(i * 4) : 6'h3c, (i == 3) ? 32'hf : (i == 7) ? 32'h8000 :
            (i == 8) ? 32'h7fff : 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         w = (i == 0) ? 32'hffff_ffb0 : $urandom;
         wr(6'h0c, w);
         rchk("setup", 6'h0c, exp_setup(w));
         chk("setup pins", {25'h0, conv_vcal, 2'h0, conv_res, conv_fmt}, exp_setup(w));
         wr(6'h08, w);
         rchk("status", 6'h08, 32'h0);
         for (int k = 4; k < 10; k++)
         begin
            wr(6'(k * 4), w);
            rchk("rw", 6'(k * 4), (k == 9) ? w & 32'h7 : w & 32'hffff);
         end
         chk("cal a pins", {16'h0, cal_a}, w & 32'hffff);
         chk("cal b pins", {16'h0, cal_b}, w & 32'hffff);
         chk("cal alpha pins", {16'h0, cal_alpha}, w & 32'hffff);
      end
      $display("test registers done");
      for (int i = 0; i < 24; i++)
      begin
         s = $urandom & 32'h4f;
         lo = $urandom & 32'hffff;
         hi = $urandom & 32'hffff;
         en = $urandom & 32'h7;
         c = (i == 0) ? lo : (i == 1) ? hi : $urandom & 32'hffff;
         r = $urandom & 32'hffff;
         f = 5'($urandom);
         ev = exp_evt(c[15:0], lo[15:0], hi[15:0]);
         wr(6'h0c, s);
         wr(6'h1c, lo);
         wr(6'h20, hi);
         wr(6'h24, en);
         wr(6'h00, 32'h1);
         #1 chk("start", {31'h0, conv_start}, 32'h1);
         conv(r[15:0], c[15:0], f);
         #1 chk("start end", {31'h0, conv_start}, 32'h0);
         chk("irq", {31'h0, sensor_irq}, {31'h0, |(ev & en)});
         w = exp_setup(s);
         rchk("status", 6'h08, {23'h0, s[0], w[3:1], f});
         rchk("raw", 6'h28, ev);
         rchk("masked", 6'h2c, ev & en);
         w = $urandom & 32'h7;
         wr(6'h30, w);
         rchk("clear", 6'h28, ev & ~w);
         rchk("result", 6'h04, s[0] ? c : r);
         rchk("read clear", 6'h28, 32'h0);
      end
      $display("test conversions done");
      give_verdict();
   end
endmodule
